// ---- shared/ssc_pkg.sv ----
/*
 * Package of the serial port status and control block: register offsets,
 * field positions, reset values, timing constants and carrier structs.
 * Assumes a 40 MHz APB clock and a 32-bit APB data path.
 */
package ssc_pkg;

    // Register byte offsets, one aligned word each
    localparam logic [7:0] SSC_OFF_CTRL_B  = 8'h00;
    localparam logic [7:0] SSC_OFF_STATUS  = 8'h04;
    localparam logic [7:0] SSC_OFF_MODE    = 8'h08;
    localparam logic [7:0] SSC_OFF_PFUNC_C = 8'h10;
    localparam logic [7:0] SSC_OFF_PDIR_C  = 8'h14;
    localparam logic [7:0] SSC_OFF_PDATA_C = 8'h18;
    localparam logic [7:0] SSC_OFF_PFUNC_D = 8'h20;
    localparam logic [7:0] SSC_OFF_PDIR_D  = 8'h24;
    localparam logic [7:0] SSC_OFF_PDATA_D = 8'h28;

    // Control register B fields
    localparam int SSC_CB_OUT_FLAG0 = 0;
    localparam int SSC_CB_OUT_FLAG1 = 1;
    localparam int SSC_CB_DIR0      = 2;
    localparam int SSC_CB_DIR1      = 3;
    localparam int SSC_CB_SHARED    = 12;
    localparam int SSC_CB_SLOTMODE  = 13;
    localparam int SSC_CB_TX2_ON    = 14;
    localparam int SSC_CB_TX1_ON    = 15;
    localparam int SSC_CB_TX0_ON    = 16;
    localparam int SSC_CB_RX_ON     = 17;
    localparam int SSC_CB_TIE       = 18;
    localparam int SSC_CB_RIE       = 19;
    localparam int SSC_CB_TX_LAST_SLOT_IRQ_EN      = 20;
    localparam int SSC_CB_RX_LAST_SLOT_IRQ_EN      = 21;
    localparam int SSC_CB_TX_EXCEPTION_IRQ_EN      = 22;
    localparam int SSC_CB_RX_EXCEPTION_IRQ_EN      = 23;

    // Status register fields
    localparam int SSC_ST_IF0 = 0;
    localparam int SSC_ST_IF1 = 1;
    localparam int SSC_ST_TFS = 2;
    localparam int SSC_ST_RFS = 3;
    localparam int SSC_ST_TUE = 4;
    localparam int SSC_ST_ROE = 5;
    localparam int SSC_ST_TDE = 6;
    localparam int SSC_ST_RDF = 7;

    // Widths and reset values
    localparam int          SSC_CB_W        = 24;
    localparam int          SSC_PIN_W       = 5;
    localparam logic [23:0] SSC_CB_RESET    = 24'h000000;
    localparam logic [4:0]  SSC_PORT_RESET  = 5'h00;
    localparam logic [7:0]  SSC_ST_RESET    = 8'h40;

    // Pin assignment within a port: aux pins are port bits 0 and 1
    localparam int SSC_PIN_AUX0 = 0;
    localparam int SSC_PIN_AUX1 = 1;

    // Link timing: flag pins settle for a bounded time before sampling
    localparam int SSC_CLK_MHZ       = 40;
    localparam int SSC_FLAG_HOLD_NS  = 50;
    localparam int SSC_FLAG_HOLD_CYC = (SSC_FLAG_HOLD_NS * SSC_CLK_MHZ + 999) / 1000;

    // Events from the shift datapath, one-cycle pulses in pclk domain
    typedef struct packed {
        logic tx_slot;        // Transmit time slot begins
        logic tx_frame;       // Transmit frame sync in this slot
        logic tx_load;        // Holding registers moved to shifters
        logic rx_slot;        // Receive time slot begins
        logic rx_frame;       // Receive frame sync in this slot
        logic rx_xfer;        // Receive shifter moved to holding
        logic rx_read;        // Core read the receive holding register
    } ssc_event_type;

    // Holding register state from the datapath
    typedef struct packed {
        logic [2:0] tx_written;   // Per-transmitter holding written
        logic [2:0] tx_shift_mt;  // Per-transmitter shifter empty
    } ssc_hold_type;

    // Interrupt request lines to the core
    typedef struct packed {
        logic tx_data;
        logic rx_data;
        logic tx_last;
        logic rx_last;
        logic tx_exc;
        logic rx_exc;
    } ssc_irq_type;

endpackage

// ---- rtl/ssc_gpio_port.sv ----
/*
 * One five-pin port that shares its pins between the serial port and
 * general-purpose I/O. Assumes pin inputs are already synchronised.
 */
`timescale 1ns/10ps

module ssc_gpio_port
    import ssc_pkg::*;
#(
    parameter int PIN_W = 5
) (
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Register writes
    input  wire logic             wr_func,
    input  wire logic             wr_dir,
    input  wire logic             wr_data,
    input  wire logic [PIN_W-1:0] wdata,
    // Register contents
    output logic [PIN_W-1:0]      func_ff,
    output logic [PIN_W-1:0]      dir_ff,
    output logic [PIN_W-1:0]      data_rd,
    // Serial side of the pins
    input  wire logic [PIN_W-1:0] ser_out,
    input  wire logic [PIN_W-1:0] ser_oe,
    // Synchronised pin levels and pin drivers
    input  wire logic [PIN_W-1:0] pin_sync,
    output logic [PIN_W-1:0]      pin_out,
    output logic [PIN_W-1:0]      pin_oe
);

    // Elaboration guard: registers and read-back assume 2 to 32 pins
    if (PIN_W < 2 || PIN_W > 32) begin : g_bad_pin_w
        $error("PIN_W out of range");
    end

    logic [PIN_W-1:0] data_ff;

    ////////////////////////////////////////////////////////////////////////
    // Port registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            func_ff <= SSC_PORT_RESET;
            dir_ff  <= SSC_PORT_RESET;
            data_ff <= SSC_PORT_RESET;
        end else begin
            if (wr_func) func_ff <= wdata;
            if (wr_dir)  dir_ff  <= wdata;
            if (wr_data) data_ff <= wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin muxing, per bit
    genvar i;
    generate
        for (i = 0; i < PIN_W; i++) begin : g_pin
            // Function bit picks serial port or GPIO
            assign pin_out[i] = func_ff[i] ? ser_out[i] : data_ff[i];
            // Direction only counts in GPIO mode
            assign pin_oe[i]  = func_ff[i] ? ser_oe[i] : dir_ff[i];
            // Inputs read the pin, outputs read back the written value
            assign data_rd[i] = (!func_ff[i] && !dir_ff[i]) ? pin_sync[i] : data_ff[i];
        end
    endgenerate

    gpio_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!func_ff[0] && dir_ff[0]) |-> (pin_oe[0] && pin_out[0] == data_ff[0]))
        else $error("GPIO output pin 0 not driven from data");

endmodule // ssc_gpio_port

// ---- rtl/ssc_top.sv ----
/*
 * Status and control of one synchronous serial port, with the pin
 * sharing port registers, on an APB slave. The shift datapath lives
 * elsewhere and reports its events as one-cycle pulses on pclk.
 * Assumes serial pins arrive asynchronous and are synchronised here.
 */
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/10ps

// Operation
// - Enable bits: tx1 bit15, tx0 bit16, rx bit17
// - Data and last-slot interrupt enables, bits 18-21
// - Exception interrupt enables at bits 22, 23
// - Status bit0 shows aux pin 0 level
// - Status bit1 shows aux pin 1 level
// - Status bit2 tx frame sync this slot
// - Status bit3 rx frame sync this slot
// - Underrun when slot meets empty enabled shifter
// - Overrun when receive holding still unread
// - Tx empty sets on load, clears all written
// - Rx full sets on transfer, clears on read
// - Function bit: serial when 1, GPIO 0
// - GPIO direction: output when 1
// - GPIO data reads pin, drives output
// - Two identical ports, own pin registers
// - Shared timing bit selects common clock/sync
// - Tx1, tx2, flags unusable in separate timing
// - Flags update at frame or slot start; output flags here change on each control register B write
module ssc_top
    import ssc_pkg::*;
#(
    parameter int PIN_W = SSC_PIN_W
) (
    // APB slave
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic [31:0]           prdata,
    output logic                  pready,
    output logic                  pslverr,
    // Datapath events and state
    input  wire ssc_event_type    evt,
    input  wire ssc_hold_type     hold,
    // Interrupt requests to the core
    output ssc_irq_type           irq,
    // Timing and enables toward the datapath
    output logic                  shared_timing_mode,
    output logic                  slot_mode_select,
    output logic [2:0]            tx_active,
    output logic                  rx_active,
    // Serial functions that want pins of port C
    input  wire logic [PIN_W-1:0] ser_out_c,
    input  wire logic [PIN_W-1:0] ser_oe_c,
    // Pins of port C
    input  wire logic [PIN_W-1:0] pin_in_c,
    output logic [PIN_W-1:0]      pin_out_c,
    output logic [PIN_W-1:0]      pin_oe_c,
    // Pins of port D
    input  wire logic [PIN_W-1:0] pin_in_d,
    output logic [PIN_W-1:0]      pin_out_d,
    output logic [PIN_W-1:0]      pin_oe_d
);

    // Elaboration guard: the read mux only has room for 2 to 32 pins
    if (PIN_W < 2 || PIN_W > 32) begin : g_bad_pin_w
        $error("PIN_W out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [SSC_CB_W-1:0] ctrl_ff;
    logic [7:0]          status;
    logic                tue_ff, roe_ff, tde_ff, rdf_ff;
    logic                tfs_ff, rfs_ff;
    logic                if0_ff, if1_ff;
    logic [PIN_W-1:0]    sync1_c, sync2_c, sync1_d, sync2_d;
    logic [PIN_W-1:0]    func_c, dir_c, rd_c, func_d, dir_d, rd_d;
    logic [PIN_W-1:0]    ser_out_mux, ser_oe_mux;
    logic                wr_en, rd_en;
    logic                tx_written_all;
    logic                nxt_tde;
    logic                flag_tick;

    // Address match helper shared by write and read decode
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // APB handshake: zero wait state, error on unmapped address
    assign wr_en  = psel && penable && pwrite;
    assign rd_en  = psel && penable && !pwrite;
    assign pready = 1'b1;

    always_comb begin
        pslverr = 1'b0;
        if (psel && penable) begin
            pslverr = !(hit(paddr, SSC_OFF_CTRL_B) || hit(paddr, SSC_OFF_STATUS) ||
                        hit(paddr, SSC_OFF_MODE) ||
                        hit(paddr, SSC_OFF_PFUNC_C) || hit(paddr, SSC_OFF_PDIR_C) ||
                        hit(paddr, SSC_OFF_PDATA_C) || hit(paddr, SSC_OFF_PFUNC_D) ||
                        hit(paddr, SSC_OFF_PDIR_D) || hit(paddr, SSC_OFF_PDATA_D));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control register B, including timing mode bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= SSC_CB_RESET;
        end else if (wr_en && hit(paddr, SSC_OFF_CTRL_B)) begin
            ctrl_ff <= pwdata[SSC_CB_W-1:0];
        end
    end

    assign shared_timing_mode = ctrl_ff[SSC_CB_SHARED];
    assign slot_mode_select   = ctrl_ff[SSC_CB_SLOTMODE];

    // Tx1 and tx2 only run when timing is shared
    assign tx_active[0] = ctrl_ff[SSC_CB_TX0_ON];
    assign tx_active[1] = ctrl_ff[SSC_CB_TX1_ON] && shared_timing_mode;
    assign tx_active[2] = ctrl_ff[SSC_CB_TX2_ON] && shared_timing_mode;
    assign rx_active    = ctrl_ff[SSC_CB_RX_ON];

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; first stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_c <= '0;
            sync2_c <= '0;
            sync1_d <= '0;
            sync2_d <= '0;
        end else begin
            sync1_c <= pin_in_c;
            sync2_c <= sync1_c;
            sync1_d <= pin_in_d;
            sync2_d <= sync1_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial pin ownership on port C: in shared timing, aux pins become flag
    // outputs when no transmitter claims them; tx1 and tx2 data come from the datapath
    always_comb begin
        ser_out_mux = ser_out_c;
        ser_oe_mux  = ser_oe_c;
        if (shared_timing_mode && !tx_active[1]) begin
            ser_out_mux[SSC_PIN_AUX0] = ctrl_ff[SSC_CB_OUT_FLAG0];
            ser_oe_mux[SSC_PIN_AUX0]  = ctrl_ff[SSC_CB_DIR0];
        end
        if (shared_timing_mode && !tx_active[2]) begin
            ser_out_mux[SSC_PIN_AUX1] = ctrl_ff[SSC_CB_OUT_FLAG1];
            ser_oe_mux[SSC_PIN_AUX1]  = ctrl_ff[SSC_CB_DIR1];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Input flags: sampled at frame start in normal mode, slot start in
    // network mode, so software sees a value stable across the unit
    assign flag_tick = slot_mode_select ? (evt.tx_slot || evt.rx_slot)
                                        : (evt.tx_frame || evt.rx_frame);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            if0_ff <= 1'b0;
            if1_ff <= 1'b0;
        end else if (flag_tick && shared_timing_mode) begin
            if (!tx_active[1] && !ctrl_ff[SSC_CB_DIR0])
                if0_ff <= sync2_c[SSC_PIN_AUX0];
            if (!tx_active[1] && !tx_active[2] && !ctrl_ff[SSC_CB_DIR1])
                if1_ff <= sync2_c[SSC_PIN_AUX1];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Frame sync seen flags, refreshed at each slot; forced 1 in normal mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tfs_ff <= 1'b0;
            rfs_ff <= 1'b0;
        end else begin
            if (evt.tx_slot) tfs_ff <= evt.tx_frame;
            if (evt.rx_slot) rfs_ff <= evt.rx_frame;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Underrun and overrun. These are sticky; the status read clears them,
    // but a new event in the read cycle wins over the clear.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tue_ff <= 1'b0;
            roe_ff <= 1'b0;
        end else begin
            if (evt.tx_slot && |(hold.tx_shift_mt & tx_active))
                tue_ff <= 1'b1;
            else if (rd_en && hit(paddr, SSC_OFF_STATUS))
                tue_ff <= 1'b0;
            if (evt.rx_xfer && rdf_ff && !evt.rx_read)
                roe_ff <= 1'b1;
            else if (rd_en && hit(paddr, SSC_OFF_STATUS))
                roe_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmit empty: set on load, cleared when every enabled holding
    // register is written; load wins over a same-cycle final write
    assign tx_written_all = ((hold.tx_written & tx_active) == tx_active);

    always_comb begin
        nxt_tde = tde_ff;
        if (evt.tx_load)
            nxt_tde = 1'b1;
        else if (tde_ff && tx_written_all && |tx_active)
            nxt_tde = 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) tde_ff <= 1'b1;
        else          tde_ff <= nxt_tde;
    end

    // Receive full: transfer wins over a same-cycle read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)          rdf_ff <= 1'b0;
        else if (evt.rx_xfer)  rdf_ff <= 1'b1;
        else if (evt.rx_read)  rdf_ff <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Status word
    always_comb begin
        status               = 8'h00;
        status[SSC_ST_IF0]   = if0_ff;
        status[SSC_ST_IF1]   = if1_ff;
        status[SSC_ST_TFS]   = slot_mode_select ? tfs_ff : 1'b1;
        status[SSC_ST_RFS]   = slot_mode_select ? rfs_ff : 1'b1;
        status[SSC_ST_TUE]   = tue_ff;
        status[SSC_ST_ROE]   = roe_ff;
        status[SSC_ST_TDE]   = tde_ff;
        status[SSC_ST_RDF]   = rdf_ff;
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt requests follow flag AND enable, no latching here
    assign irq.tx_data = tde_ff && ctrl_ff[SSC_CB_TIE];
    assign irq.rx_data = rdf_ff && ctrl_ff[SSC_CB_RIE];
    assign irq.tx_last = evt.tx_slot && ctrl_ff[SSC_CB_TX_LAST_SLOT_IRQ_EN];
    assign irq.rx_last = evt.rx_slot && ctrl_ff[SSC_CB_RX_LAST_SLOT_IRQ_EN];
    assign irq.tx_exc  = tue_ff && ctrl_ff[SSC_CB_TX_EXCEPTION_IRQ_EN];
    assign irq.rx_exc  = roe_ff && ctrl_ff[SSC_CB_RX_EXCEPTION_IRQ_EN];

    ////////////////////////////////////////////////////////////////////////
    // Two identical pin ports
    ssc_gpio_port #(.PIN_W(PIN_W)) u_port_c (
        .pclk     (pclk),
        .presetn  (presetn),
        .wr_func  (wr_en && hit(paddr, SSC_OFF_PFUNC_C)),
        .wr_dir   (wr_en && hit(paddr, SSC_OFF_PDIR_C)),
        .wr_data  (wr_en && hit(paddr, SSC_OFF_PDATA_C)),
        .wdata    (pwdata[PIN_W-1:0]),
        .func_ff  (func_c),
        .dir_ff   (dir_c),
        .data_rd  (rd_c),
        .ser_out  (ser_out_mux),
        .ser_oe   (ser_oe_mux),
        .pin_sync (sync2_c),
        .pin_out  (pin_out_c),
        .pin_oe   (pin_oe_c)
    );

    // Port D serial side is owned by the second serial port, idle here
    ssc_gpio_port #(.PIN_W(PIN_W)) u_port_d (
        .pclk     (pclk),
        .presetn  (presetn),
        .wr_func  (wr_en && hit(paddr, SSC_OFF_PFUNC_D)),
        .wr_dir   (wr_en && hit(paddr, SSC_OFF_PDIR_D)),
        .wr_data  (wr_en && hit(paddr, SSC_OFF_PDATA_D)),
        .wdata    (pwdata[PIN_W-1:0]),
        .func_ff  (func_d),
        .dir_ff   (dir_d),
        .data_rd  (rd_d),
        .ser_out  ('0),
        .ser_oe   ('0),
        .pin_sync (sync2_d),
        .pin_out  (pin_out_d),
        .pin_oe   (pin_oe_d)
    );

    ////////////////////////////////////////////////////////////////////////
    // Read mux, registered-free since APB samples in access phase
    always_comb begin
        prdata = 32'h00000000;
        case (paddr)
            SSC_OFF_CTRL_B:  prdata[SSC_CB_W-1:0] = ctrl_ff;
            SSC_OFF_STATUS:  prdata[7:0]          = status;
            SSC_OFF_MODE:    prdata[1:0]          = {slot_mode_select, shared_timing_mode};
            SSC_OFF_PFUNC_C: prdata[PIN_W-1:0]    = func_c;
            SSC_OFF_PDIR_C:  prdata[PIN_W-1:0]    = dir_c;
            SSC_OFF_PDATA_C: prdata[PIN_W-1:0]    = rd_c;
            SSC_OFF_PFUNC_D: prdata[PIN_W-1:0]    = func_d;
            SSC_OFF_PDIR_D:  prdata[PIN_W-1:0]    = dir_d;
            SSC_OFF_PDATA_D: prdata[PIN_W-1:0]    = rd_d;
            default:         prdata               = 32'h00000000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    tx1_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        !shared_timing_mode |-> !tx_active[1] && !tx_active[2])
        else $error("tx1 or tx2 active in separate timing");

    ctrl_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == SSC_OFF_CTRL_B) |=> rx_active == $past(pwdata[17]))
        else $error("Receive enable not taken from write");

    tfs_normal_a: assert property (@(posedge pclk) disable iff (!presetn)
        !slot_mode_select |-> status[2] && status[3])
        else $error("Frame sync flags not 1 in normal mode");

    underrun_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        (evt.tx_slot && |(hold.tx_shift_mt & tx_active)) |=> tue_ff)
        else $error("Underrun not flagged");

    overrun_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        (evt.rx_xfer && rdf_ff && !evt.rx_read) |=> roe_ff)
        else $error("Overrun not flagged");

    tde_load_a: assert property (@(posedge pclk) disable iff (!presetn)
        evt.tx_load |=> tde_ff)
        else $error("Transmit empty not set by load");

    rdf_cycle_a: assert property (@(posedge pclk) disable iff (!presetn)
        (evt.rx_xfer ##1 (evt.rx_read && !evt.rx_xfer)) |=> !rdf_ff)
        else $error("Receive full not cleared by read");

    irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
        irq.rx_exc == (roe_ff && ctrl_ff[23]))
        else $error("Receive exception request wrong");

    flag_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        !flag_tick |=> $stable(if0_ff) && $stable(if1_ff))
        else $error("Input flag moved between frame or slot starts");

endmodule // ssc_top

// ---- sim/ssc_far_model.sv ----
/*
 * Far side of the shared pins: codecs or GPIO loads on ports C and D.
 * Assumes the bench sets the levels the far side drives when released.
 */
`timescale 1ns/10ps

module ssc_far_model
    import ssc_pkg::*;
(
    // Device pin drivers
    input  wire logic [4:0] pin_out_c,
    input  wire logic [4:0] pin_oe_c,
    input  wire logic [4:0] pin_out_d,
    input  wire logic [4:0] pin_oe_d,
    // Levels the far side puts on released pins
    input  wire logic [4:0] ext_c,
    input  wire logic [4:0] ext_d,
    // Resolved wire levels
    output logic [4:0]      pin_in_c,
    output logic [4:0]      pin_in_d
);
    // Device wins where it drives; far side never fights an output
    assign pin_in_c = (pin_oe_c & pin_out_c) | (~pin_oe_c & ext_c);
    assign pin_in_d = (pin_oe_d & pin_out_d) | (~pin_oe_d & ext_d);
endmodule // ssc_far_model

// ---- sim/tb.sv ----
/*
 * Self-checking bench: APB register access, datapath event pulses, pins.
 * Assumes zero-wait APB slave and one-cycle event pulses on pclk.
 */
`timescale 1ns/10ps

module tb
    import ssc_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, stm, smd, rxa, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [2:0] txa;
    logic [4:0] soc, soe, pic, poc, pec, pid, pod, ped, exc, exd;
    ssc_event_type evt;
    ssc_hold_type hold;
    ssc_irq_type irq;
    int fail_count = 0, n_compared = 0, cyc = 0;

    ssc_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .evt(evt),
        .hold(hold), .irq(irq), .shared_timing_mode(stm), .slot_mode_select(smd), .tx_active(txa),
        .rx_active(rxa), .ser_out_c(soc), .ser_oe_c(soe), .pin_in_c(pic), .pin_out_c(poc),
        .pin_oe_c(pec), .pin_in_d(pid), .pin_out_d(pod), .pin_oe_d(ped));
    ssc_far_model far_u (.pin_out_c(poc), .pin_oe_c(pec), .pin_out_d(pod), .pin_oe_d(ped),
        .ext_c(exc), .ext_d(exd), .pin_in_c(pic), .pin_in_d(pid));

    ////////////////////////////////////////////////////////////////////////
    // Clock and hang guard
    initial begin
        pclk = 0;
        forever #12.5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 0; penable <= 0;
        @(posedge pclk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Single-cycle event pulse, then two settle cycles
    task automatic pulse(input logic [6:0] m);
        evt <= ssc_event_type'(m);
        @(posedge pclk);
        evt <= '0;
        repeat (2) @(posedge pclk);
    endtask
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Test sequence
    initial begin
        presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
        evt = '0; hold = '0; soc = 5'h08; soe = 5'h1f; exc = 5'h05; exd = 5'h00;
        repeat (16) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        apb(0, SSC_OFF_STATUS, 0); chk(r, 32'h4c);
        apb(1, SSC_OFF_CTRL_B, 32'hff9000);
        apb(0, SSC_OFF_CTRL_B, 0); chk(r, 32'hff9000);
        chk({irq, smd, txa, rxa, stm}, 12'h80f);
        $display("control test done");
        hold <= '{tx_written: 3'h0, tx_shift_mt: 3'h1};
        evt <= ssc_event_type'(7'h02);
        @(posedge pclk);
        pulse(7'h01); chk(irq.rx_data, 0);
        pulse(7'h02); chk(irq.rx_data, 1);
        apb(0, SSC_OFF_STATUS, 0); chk(r, 32'hcc);
        pulse(7'h02); chk(irq.rx_exc, 1);
        apb(0, SSC_OFF_STATUS, 0); chk(r, 32'hec);
        pulse(7'h01); pulse(7'h40); chk(irq.tx_exc, 1);
        apb(0, SSC_OFF_STATUS, 0); chk(r, 32'h5c);
        hold <= '{tx_written: 3'h3, tx_shift_mt: 3'h0};
        repeat (2) @(posedge pclk);
        apb(0, SSC_OFF_STATUS, 0); chk(r, 32'h0c);
        hold <= '0;
        pulse(7'h10);
        apb(0, SSC_OFF_STATUS, 0); chk(r, 32'h4c);
        $display("status test done");
        apb(1, SSC_OFF_CTRL_B, 32'h001000);
        pulse(7'h20);
        apb(0, SSC_OFF_STATUS, 0); chk(r, 32'h4d);
        apb(1, SSC_OFF_CTRL_B, 32'h333000);
        apb(0, SSC_OFF_MODE, 0); chk(r, 32'h3);
        evt <= ssc_event_type'(7'h60);
        #1 chk({irq.tx_last, irq.rx_last}, 2'h2);
        @(posedge pclk);
        evt <= '0;
        repeat (2) @(posedge pclk);
        apb(0, SSC_OFF_STATUS, 0); chk(r, 32'h45);
        pulse(7'h4c);
        apb(0, SSC_OFF_STATUS, 0); chk(r, 32'h49);
        $display("network test done");
        apb(1, SSC_OFF_PDIR_C, 32'h0a); apb(1, SSC_OFF_PDATA_C, 0);
        apb(0, SSC_OFF_PDATA_C, 0); chk(r, 32'h05);
        chk(pec, 5'h0a);
        apb(1, SSC_OFF_PDIR_D, 32'h1f); apb(1, SSC_OFF_PDATA_D, 32'h13);
        apb(0, SSC_OFF_PDATA_D, 0); chk(r, 32'h13);
        chk({ped, pod}, 10'h3f3);
        apb(1, SSC_OFF_PFUNC_C, 32'h1f);
        chk({pec[4:2], poc[4:2]}, 6'h3a);
        apb(0, 8'h30, 0); chk(e, 1);
        chk(r, 0);
        $display("port test done");
        tally_and_finish();
    end
endmodule // tb
